// ### src/dmach_core.sv
// Core-side end: AXI4-Lite command registers, interrupt gating, memory and arbitration
//
// Design decision made here: the AXI4-Lite slave port.
`include "dmach_defs.svh"
module dmach_core
  import dmach_pkg::*;
#(
  parameter int MEM_AW = 8
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core activity, same clock
  input  wire logic        core_mem_in,
  input  wire logic        core_exp_in,
  // Core interrupt
  output logic             core_irq_out,
  // Channel link
  dmach_if.core            bus
);
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [23:0] raddr;
    logic [31:0] rwdata;
    logic [31:0] rres;
    logic        busy;
    logic        reg_wr;
    logic        reg_rd;
    logic [3:0]  idx;
    logic [31:0] flag;
    logic [31:0] ien;
    logic [31:0] cst;
    logic        irq;
    logic        gnt;
    logic [31:0] mrdata;
    logic        last_core;
  } dmach_co_t;

  dmach_co_t s;
  dmach_co_t n;
  logic [31:0] mem [0:(1 << MEM_AW) - 1];

  logic       periph;
  logic       conflict;
  logic       chan_wins;
  logic       grant;
  logic [23:0] off;

  always_comb begin
    n          = s;
    n.reg_wr   = 1'b0;
    n.reg_rd   = 1'b0;
    off        = s.raddr - `DMACH_BASE;
    // Write channel
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      if (s.awaddr == `DMACH_A_RADDR) begin
        n.raddr = s.wdata[23:0];
      end else if (s.awaddr == `DMACH_A_WDATA) begin
        n.rwdata = s.wdata;
      end else if (s.awaddr == `DMACH_A_GO) begin
        // Only the channel window is forwarded; other addresses are dropped
        if (!s.busy && off < 24'h000010 && s.raddr >= `DMACH_BASE) begin
          n.busy   = 1'b1;
          n.idx    = off[3:0];
          n.reg_rd = s.wdata[0];
          n.reg_wr = s.wdata[1] & ~s.wdata[0];
          n.busy   = s.wdata[0] | s.wdata[1];
        end
      end else if (s.awaddr == `DMACH_A_IEN) begin
        n.ien = s.wdata;
      end else if (s.awaddr == `DMACH_A_CST) begin
        n.cst = s.wdata;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    // Read channel
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      if (s_axi_araddr == `DMACH_A_RADDR) begin
        n.rdata = {8'h00, s.raddr};
      end else if (s_axi_araddr == `DMACH_A_WDATA) begin
        n.rdata = s.rwdata;
      end else if (s_axi_araddr == `DMACH_A_RDATA) begin
        n.rdata = s.rres;
      end else if (s_axi_araddr == `DMACH_A_STATUS) begin
        n.rdata = {31'h00000000, s.busy};
      end else if (s_axi_araddr == `DMACH_A_FLAG) begin
        n.rdata = s.flag;
      end else if (s_axi_araddr == `DMACH_A_IEN) begin
        n.rdata = s.ien;
      end else if (s_axi_araddr == `DMACH_A_CST) begin
        n.rdata = s.cst;
      end else begin
        n.rdata = 32'h00000000;
      end
    end
    n.arready = !n.rvalid;
    // Channel register answer
    if (bus.reg_ack) begin
      n.busy = 1'b0;
      n.rres = bus.reg_rdata;
    end
    // Completion flag: hardware set wins over write-one clear
    n.flag = s.flag;
    if (s.aw_got && s.w_got && !s.bvalid && s.awaddr == `DMACH_A_FLAG) begin
      n.flag = s.flag & ~s.wdata;
    end
    if (bus.done_irq) begin
      n.flag[`DMACH_DONE_BIT] = 1'b1;
    end
    n.irq = s.flag[`DMACH_DONE_BIT] & s.ien[`DMACH_DONE_BIT] & s.cst[`DMACH_GIE_BIT];
    // Memory arbitration
    periph    = (bus.mem_addr >= `DMACH_PERIPH_LO) && (bus.mem_addr < `DMACH_ONCHIP_LO);
    conflict  = periph ? (core_exp_in | s.busy) :
                ((bus.mem_addr >= `DMACH_ONCHIP_LO) && (bus.mem_addr <= `DMACH_ONCHIP_HI) && core_mem_in);
    if (bus.prio == PRIO_CHAN) begin
      chan_wins = 1'b1;
    end else if (bus.prio == PRIO_ROT) begin
      chan_wins = s.last_core;
    end else begin
      chan_wins = 1'b0;
    end
    grant    = bus.mem_req && (!conflict || chan_wins);
    n.gnt    = grant;
    n.mrdata = mem[bus.mem_addr[MEM_AW-1:0]];
    if (bus.mem_req && conflict) begin
      n.last_core = !chan_wins;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Shared memory; each word starts as its own index so moved data is never unknown
  for (genvar gi = 0; gi < (1 << MEM_AW); gi++) begin : g_mem
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        mem[gi] <= 32'(gi);
      end else if (grant && bus.mem_we && (bus.mem_addr[MEM_AW-1:0] == MEM_AW'(gi))) begin
        mem[gi] <= bus.mem_wdata;
      end
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = 2'h0;
  assign s_axi_rvalid  = s.rvalid;
  assign core_irq_out  = s.irq;
  assign bus.reg_idx   = s.idx;
  assign bus.reg_wr    = s.reg_wr;
  assign bus.reg_rd    = s.reg_rd;
  assign bus.reg_wdata = s.rwdata;
  assign bus.mem_gnt   = s.gnt;
  assign bus.mem_rdata = s.mrdata;
endmodule // dmach_core

// ### include/dmach_defs.svh
// Constants for the block-transfer channel and its core-side end
`ifndef DMACH_DEFS_SVH
`define DMACH_DEFS_SVH
// Channel register window, word addresses
`define DMACH_BASE        24'h808000
`define DMACH_IDX_CTRL    4'h0
`define DMACH_IDX_SRC     4'h4
`define DMACH_IDX_DST     4'h6
`define DMACH_IDX_CNT     4'h8
`define DMACH_CTRL_RST    32'h00000000
// Control word fields
`define DMACH_START_LO    0
`define DMACH_STAT_LO     2
`define DMACH_INCS        4
`define DMACH_DECS        5
`define DMACH_INCD        6
`define DMACH_DECD        7
`define DMACH_SYNC_LO     8
`define DMACH_TCC         10
`define DMACH_COMPLETION_IRQ_ENABLE       11
`define DMACH_PRIO_LO     12
`define DMACH_START_RUN   2'h3
`define DMACH_START_RST   2'h0
// Channel accesses memory in the third of four core phases
`define DMACH_ACC_PHASE   2'h2
// Address regions
`define DMACH_PERIPH_LO   24'h808000
`define DMACH_ONCHIP_LO   24'h809800
`define DMACH_ONCHIP_HI   24'h809fff
// Core-end AXI4-Lite register offsets
`define DMACH_A_RADDR     8'h00
`define DMACH_A_WDATA     8'h04
`define DMACH_A_GO        8'h08
`define DMACH_A_RDATA     8'h0c
`define DMACH_A_STATUS    8'h10
`define DMACH_A_FLAG      8'h14
`define DMACH_A_IEN       8'h18
`define DMACH_A_CST       8'h1c
// Core register bits
`define DMACH_DONE_BIT    10
`define DMACH_GIE_BIT     13
`endif

// ### include/dmach_pkg.sv
// Types shared by the channel and its core-side end
package dmach_pkg;
  typedef enum logic [4:0] {
    CH_IDLE  = 5'b00001,
    CH_RWAIT = 5'b00010,
    CH_READ  = 5'b00100,
    CH_WWAIT = 5'b01000,
    CH_WRITE = 5'b10000
  } dmach_state_t;
  typedef enum logic [1:0] {
    PRIO_CORE = 2'h0,
    PRIO_CHAN = 2'h1,
    PRIO_ROT  = 2'h2
  } dmach_prio_t;
endpackage

// ### include/dmach_if.sv
// Link between the channel and the core with its memories
interface dmach_if;
  // Register access from the core
  logic [3:0]  reg_idx;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_ack;
  // Channel memory access
  logic        mem_req;
  logic        mem_we;
  logic [23:0] mem_addr;
  logic [31:0] mem_wdata;
  logic        mem_gnt;
  logic [31:0] mem_rdata;
  // Priority and completion
  logic [1:0]  prio;
  logic        done_irq;
  modport chan (input reg_idx, reg_wr, reg_rd, reg_wdata, mem_gnt, mem_rdata,
                output reg_rdata, reg_ack, mem_req, mem_we, mem_addr, mem_wdata, prio, done_irq);
  modport core (output reg_idx, reg_wr, reg_rd, reg_wdata, mem_gnt, mem_rdata,
                input reg_rdata, reg_ack, mem_req, mem_we, mem_addr, mem_wdata, prio, done_irq);
endinterface

// ### src/dmach_channel.sv
// Block-transfer channel: registers, element sequencer, sync and completion
// Notes on behaviour
// - Own address generators, source, destination, counter.
// - One channel here; priority field per channel.
// - Reset write clears latched sync interrupts.
// - Software enables sync interrupts after starting.
// - Core wins same-memory conflicts by default.
// - Memory accesses issued in third clock phase.
// - Programmed or rotating priority against the core.
// - Peripheral access conflicts with core expansion access.
// - Sync mode waits for interrupt each element.
// - Software selects sync for serial ports.
// - Completion flag set only with completion_irq_enable.
// - Counter decrements after read; zero when done.
// - Start/status field reads zero when finished.
// - Registers reachable on peripheral bus, add contention.
// - Completion flag polling adds no contention.
// - Control at base; source, destination, counter 4/6/8.
// - Completion signalled as interrupt, core gates it.
// - Sync interrupts trigger elements, not core.
`include "dmach_defs.svh"
module dmach_channel
  import dmach_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Core link
  dmach_if.chan     bus,
  // Sync interrupt sources, same clock
  input  wire logic sync_src_in,
  input  wire logic sync_dst_in,
  // Status
  output logic      active_out
);
  typedef struct packed {
    dmach_state_t st;
    logic [1:0]   ph;
    logic [31:0]  ctrl;
    logic [31:0]  src;
    logic [31:0]  dst;
    logic [31:0]  cnt;
    logic [31:0]  data;
    logic [31:0]  rdata;
    logic         ack;
    logic         req;
    logic         we;
    logic [23:0]  maddr;
    logic [31:0]  mwdata;
    logic         rsync;
    logic         xsync;
    logic         done;
    logic         active;
  } dmach_ch_t;

  dmach_ch_t s;
  dmach_ch_t n;

  logic [1:0] sync_mode;
  logic [1:0] ph_next;
  logic       running;
  logic       redirect;

  always_comb begin
    n         = s;
    n.ack     = 1'b0;
    n.done    = 1'b0;
    // Free-running phase; requests line up with the access phase only
    ph_next   = s.ph + 2'h1;
    n.ph      = ph_next;
    sync_mode = s.ctrl[`DMACH_SYNC_LO +: 2];
    running   = (s.st != CH_IDLE);
    redirect  = 1'b0;
    // Register access from the core
    if (bus.reg_wr) begin
      if (bus.reg_idx == `DMACH_IDX_CTRL) begin
        n.ctrl = bus.reg_wdata;
        if (bus.reg_wdata[`DMACH_START_LO +: 2] == `DMACH_START_RST) begin
          n.rsync  = 1'b0;
          n.xsync  = 1'b0;
          n.st     = CH_IDLE;
          redirect = 1'b1;
        end else if (bus.reg_wdata[`DMACH_START_LO +: 2] == `DMACH_START_RUN) begin
          if (!running) begin
            n.st     = CH_RWAIT;
            redirect = 1'b1;
          end
        end else begin
          // Hold codes stop the sequence at once, in any element state, by going to CH_IDLE
          n.st     = CH_IDLE;
          redirect = 1'b1;
        end
      end else if (bus.reg_idx == `DMACH_IDX_SRC) begin
        n.src = bus.reg_wdata;
      end else if (bus.reg_idx == `DMACH_IDX_DST) begin
        n.dst = bus.reg_wdata;
      end else if (bus.reg_idx == `DMACH_IDX_CNT) begin
        n.cnt = bus.reg_wdata;
      end
    end
    if (bus.reg_rd) begin
      if (bus.reg_idx == `DMACH_IDX_CTRL) begin
        n.rdata = s.ctrl;
        n.rdata[`DMACH_STAT_LO +: 2] = running ? 2'h3 : 2'h0;
      end else if (bus.reg_idx == `DMACH_IDX_SRC) begin
        n.rdata = s.src;
      end else if (bus.reg_idx == `DMACH_IDX_DST) begin
        n.rdata = s.dst;
      end else if (bus.reg_idx == `DMACH_IDX_CNT) begin
        n.rdata = s.cnt;
      end else begin
        n.rdata = 32'h00000000;
      end
    end
    n.ack = bus.reg_wr | bus.reg_rd;
    // Element sequencer, skipped only when a control write redirects it;
    // a rewrite that keeps the block running must not lose a grant
    if (!redirect) begin
      case (s.st)
        CH_RWAIT: begin
          if (!sync_mode[0] || s.rsync) begin
            n.rsync = 1'b0;
            n.st    = CH_READ;
          end
        end
        CH_READ: begin
          if (bus.mem_gnt) begin
            n.data = bus.mem_rdata;
            // Count drops at the read, so zero shows before the last write lands
            n.cnt  = s.cnt - 32'h00000001;
            n.st   = CH_WWAIT;
          end
        end
        CH_WWAIT: begin
          if (!sync_mode[1] || s.xsync) begin
            n.xsync = 1'b0;
            n.st    = CH_WRITE;
          end
        end
        CH_WRITE: begin
          if (bus.mem_gnt) begin
            if (s.ctrl[`DMACH_INCS]) begin
              n.src = s.src + 32'h00000001;
            end else if (s.ctrl[`DMACH_DECS]) begin
              n.src = s.src - 32'h00000001;
            end
            if (s.ctrl[`DMACH_INCD]) begin
              n.dst = s.dst + 32'h00000001;
            end else if (s.ctrl[`DMACH_DECD]) begin
              n.dst = s.dst - 32'h00000001;
            end
            if (s.ctrl[`DMACH_TCC] && s.cnt == 32'h00000000) begin
              n.st = CH_IDLE;
              n.ctrl[`DMACH_START_LO +: 2] = 2'h0;
              n.done = s.ctrl[`DMACH_COMPLETION_IRQ_ENABLE];
            end else begin
              n.st = CH_RWAIT;
            end
          end
        end
        default: begin
          n.st = CH_IDLE;
        end
      endcase
    end
    // Events arriving with a reset write survive it
    if (sync_src_in) begin
      n.rsync = 1'b1;
    end
    if (sync_dst_in) begin
      n.xsync = 1'b1;
    end
    // Request only in the access phase; retried each core cycle until granted
    n.req    = ((n.st == CH_READ) || (n.st == CH_WRITE)) && !bus.mem_gnt
               && (ph_next == `DMACH_ACC_PHASE);
    if (s.st == CH_READ && bus.mem_gnt && n.st == CH_WRITE) begin
      n.req = 1'b0;
    end
    // Direction and address held steady while a request is retried
    n.we     = (n.st == CH_WRITE);
    n.maddr  = (n.st == CH_WRITE) ? n.dst[23:0] : n.src[23:0];
    n.mwdata = n.data;
    n.active = (n.st != CH_IDLE);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s        <= '0;
      s.st     <= CH_IDLE;
      s.ctrl   <= `DMACH_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  assign bus.reg_rdata = s.rdata;
  assign bus.reg_ack   = s.ack;
  assign bus.mem_req   = s.req;
  assign bus.mem_we    = s.we;
  assign bus.mem_addr  = s.maddr;
  assign bus.mem_wdata = s.mwdata;
  // Priority is only read by the core-end arbiter
  assign bus.prio      = s.ctrl[`DMACH_PRIO_LO +: 2];
  assign bus.done_irq  = s.done;
  assign active_out    = s.active;
endmodule // dmach_channel

// ### dv/dmach_asserts.sv
// Concurrent checks on the link between the channel and the core end
`include "dmach_defs.svh"
module dmach_asserts (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_in,
  // Link signals
  input wire logic [3:0]  reg_idx,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_gnt,
  input wire logic [31:0] mem_rdata,
  input wire logic [1:0]  prio,
  input wire logic        done_irq
);
  typedef struct packed {
    logic        lwe;
    logic        pend;
    logic        completion_irq_enable;
    logic [31:0] cap;
  } dmach_chk_t;
  dmach_chk_t st;
  dmach_chk_t next_st;
  logic       wr0;
  assign wr0 = reg_wr && (reg_idx == 4'h0);
  // Pending write after a read grant, and the word that read returned
  always_comb begin
    next_st = st;
    if (mem_req)
      next_st.lwe = mem_we;
    if (mem_gnt) begin
      next_st.pend = !st.lwe;
      if (!st.lwe)
        next_st.cap = mem_rdata;
    end
    if (wr0) begin
      next_st.pend = 1'b0;
      next_st.completion_irq_enable = reg_wdata[`DMACH_COMPLETION_IRQ_ENABLE];
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ack_follows_access_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("register access without acknowledge");
  ack_has_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("acknowledge without access");
  req_phase_gap_a: assert property (mem_req |=> !mem_req [*3])
    else $error("memory request outside its phase");
  req_retry_a: assert property (mem_req ##1 !mem_gnt |-> ##3 mem_req)
    else $error("refused request not retried");
  gnt_needs_req_a: assert property (mem_gnt |-> $past(mem_req))
    else $error("grant without request");
  read_before_write_a: assert property (mem_req |-> (mem_we == st.pend))
    else $error("read and write out of order");
  data_passes_a: assert property (mem_req && mem_we |-> (mem_wdata == st.cap))
    else $error("written word differs from word read");
  done_needs_enable_a: assert property (done_irq |-> st.completion_irq_enable)
    else $error("completion without its enable");
  done_pulse_a: assert property (done_irq |=> !done_irq)
    else $error("completion longer than one cycle");
  prio_follows_ctrl_a: assert property (wr0 |-> ##3 (prio == $past(reg_wdata[13:12], 3)))
    else $error("priority differs from control word");
  cover property (done_irq);
  cover property (mem_req ##1 !mem_gnt);
  cover property (mem_gnt && st.lwe);
  cover property (reg_ack && $past(reg_wr));
endmodule // dmach_asserts

// ### dv/dmach_test.sv
// Bench joining the core end and the channel, driven over AXI4-Lite
`include "dmach_defs.svh"
module dmach_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, rst_in;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        core_mem_in, core_exp_in, core_irq_out, sync_src_in, sync_dst_in, active_out, lwe;
  logic [23:0] laddr;
  logic [24:0] glog[$];
  logic [3:0]  ix[3] = '{4'h4, 4'h6, 4'h8};
  logic [31:0] cp[5] = '{32'h0, 32'h1000, 32'h2000, 32'h0, 32'h0};
  logic [1:0]  cs[5] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h2};
  logic [23:0] ca[5] = '{24'h809900, 24'h809900, 24'h809900, 24'h808100, 24'h808100};
  logic        cb[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int          error_cnt, total_checks;
  dmach_if ifc ();
  dmach_core u_dmach_core (.mclk_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_mem_in,
    .core_exp_in, .core_irq_out, .bus(ifc));
  dmach_channel u_dmach_channel (.mclk_in, .rst_in, .bus(ifc), .sync_src_in, .sync_dst_in, .active_out);
  dmach_asserts u_dmach_asserts (.mclk_in, .rst_in, .reg_idx(ifc.reg_idx), .reg_wr(ifc.reg_wr),
    .reg_rd(ifc.reg_rd), .reg_wdata(ifc.reg_wdata), .reg_ack(ifc.reg_ack), .mem_req(ifc.mem_req),
    .mem_we(ifc.mem_we), .mem_wdata(ifc.mem_wdata), .mem_gnt(ifc.mem_gnt), .mem_rdata(ifc.mem_rdata),
    .prio(ifc.prio), .done_irq(ifc.done_irq));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Granted link accesses as {write, address}
  always @(posedge mclk_in) begin
    if (ifc.mem_req) begin
      lwe <= ifc.mem_we;
      laddr <= ifc.mem_addr;
    end
    if (ifc.mem_gnt)
      glog.push_back({lwe, laddr});
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
      bad($sformatf("value %h expected %h", g, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e)
      bad($sformatf("flag %b expected %b", g, e));
  endtask
  // One clock edge, counted against a shared bound
  task automatic edge_n(inout int n);
    @(posedge mclk_in);
    n++;
    if (n > 3000) begin
      bad("wait ran out");
      stop_test;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int   n = 0;
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      edge_n(n);
      if (s_axi_awready === 1'b1 && !ta) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !tw) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      edge_n(n);
    chk32({30'h0, s_axi_bresp}, 32'h0);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    int n = 0;
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do edge_n(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do edge_n(n); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk32({30'h0, s_axi_rresp}, 32'h0);
    s_axi_rready <= 1'b0;
  endtask
  // Channel register access through the bridge, polled until it is idle
  task automatic cha(input logic [3:0] i, input logic wr, input logic [31:0] v, output logic [31:0] r);
    logic [31:0] s;
    int          n = 0;
    axw(`DMACH_A_RADDR, {8'h00, `DMACH_BASE | {20'h0, i}});
    axw(`DMACH_A_WDATA, v);
    axw(`DMACH_A_GO, {30'h0, wr, !wr});
    do begin
      axr(`DMACH_A_STATUS, s);
      edge_n(n);
    end while (s[0] !== 1'b0);
    axr(`DMACH_A_RDATA, r);
  endtask
  task automatic run(input logic [31:0] c, input logic [23:0] s, input logic [23:0] t, input logic [31:0] k);
    cha(4'h0, 1'b1, `DMACH_CTRL_RST, d);
    cha(4'h4, 1'b1, {8'h00, s}, d);
    cha(4'h6, 1'b1, {8'h00, t}, d);
    cha(4'h8, 1'b1, k, d);
    glog.delete();
    cha(4'h0, 1'b1, c, d);
  endtask
  task automatic idle;
    int n = 0;
    do edge_n(n); while (active_out !== 1'b0);
  endtask
  task automatic seq(input logic [23:0] s, input logic [23:0] t, input int k, input int st);
    chk32(32'(glog.size()), 32'(2 * k));
    for (int i = 0; i < k; i++) begin
      chk32({7'h0, glog[2 * i]}, {8'h00, s + 24'(i * st)});
      chk32({7'h0, glog[2 * i + 1]}, {7'h0, 1'b1, t + 24'(i * st)});
    end
  endtask
  task automatic pulse(input int m);
    @(posedge mclk_in);
    sync_src_in <= (m == 0);
    sync_dst_in <= (m == 1);
    @(posedge mclk_in);
    sync_src_in <= 1'b0;
    sync_dst_in <= 1'b0;
  endtask
  initial begin
    rst_in = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {core_mem_in, core_exp_in, sync_src_in, sync_dst_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    error_cnt = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    cha(4'h0, 1'b0, '0, d);
    chk32(d, `DMACH_CTRL_RST);
    for (int i = 0; i < 3; i++)
      cha(ix[i], 1'b1, 32'h5a5a0000 | 32'(i), d);
    for (int i = 0; i < 3; i++) begin
      cha(ix[i], 1'b0, '0, d);
      chk32(d, 32'h5a5a0000 | 32'(i));
    end
    cha(4'h2, 1'b1, '1, d);
    cha(4'h2, 1'b0, '0, d);
    chk32(d, '0);
    $display("test registers done");
    axw(`DMACH_A_IEN, 32'h00000400);
    axw(`DMACH_A_CST, 32'h00002000);
    run(32'h00000c53, 24'h809800, 24'h809810, 32'h3);
    idle;
    seq(24'h809800, 24'h809810, 3, 1);
    cha(4'h8, 1'b0, '0, d);
    chk32(d, '0);
    cha(4'h0, 1'b0, '0, d);
    chk32(d & 32'hf, '0);
    axr(`DMACH_A_FLAG, d);
    chk1(d[`DMACH_DONE_BIT], 1'b1);
    chk1(core_irq_out, 1'b1);
    axw(`DMACH_A_CST, '0);
    repeat (2) @(posedge mclk_in);
    chk1(core_irq_out, 1'b0);
    axw(`DMACH_A_FLAG, 32'h00000400);
    axr(`DMACH_A_FLAG, d);
    chk1(d[`DMACH_DONE_BIT], 1'b0);
    $display("test block done");
    run(32'h000004a3, 24'h809830, 24'h809850, 32'h2);
    idle;
    seq(24'h809830, 24'h809850, 2, -1);
    axr(`DMACH_A_FLAG, d);
    chk1(d[`DMACH_DONE_BIT], 1'b0);
    $display("test descending done");
    for (int m = 0; m < 2; m++) begin
      pulse(m);
      run(32'h00000453 | (32'h100 << m), 24'h809860, 24'h809870, 32'h1);
      repeat (40) @(posedge mclk_in);
      chk32(32'(glog.size()), 32'(m));
      chk1(active_out, 1'b1);
      cha(4'h8, 1'b0, '0, d);
      chk32(d, 32'(1 - m));
      pulse(m);
      idle;
      chk32(32'(glog.size()), 32'h2);
    end
    $display("test sync done");
    for (int i = 0; i < 5; i++) begin
      {core_mem_in, core_exp_in} <= cs[i];
      run(32'h00000453 | cp[i], ca[i], ca[i] + 24'h8, 32'h1);
      repeat (40) @(posedge mclk_in);
      chk32(32'(glog.size()), cb[i] ? 32'h0 : 32'h2);
      {core_mem_in, core_exp_in} <= 2'h0;
      idle;
      chk32(32'(glog.size()), 32'h2);
    end
    $display("test conflict done");
    stop_test;
  end
endmodule // dmach_test
